// ---- logic/fasi_pkg.sv ----
package fasi_pkg;
    // Clock rate and timing figures
    localparam int unsigned CLK_HZ        = 20_000_000;
    localparam int unsigned CYC_PER_MS    = CLK_HZ / 1000;
    localparam int unsigned RETRY_MS      = 5000;
    localparam int unsigned FLASH_1HZ_MS  = 500;
    localparam int unsigned LOCATE_MS     = 500;
    localparam int unsigned FLASH_05HZ_MS = 1000;
    localparam int unsigned FLASH_2HZ_MS  = 250;
    localparam int unsigned RETRY_CYC     = RETRY_MS * CYC_PER_MS;
    localparam int unsigned FLASH_1HZ_CYC = FLASH_1HZ_MS * CYC_PER_MS;
    localparam int unsigned LOCATE_CYC    = LOCATE_MS * CYC_PER_MS;
    localparam int unsigned FLASH_05_CYC  = FLASH_05HZ_MS * CYC_PER_MS;
    localparam int unsigned FLASH_2HZ_CYC = FLASH_2HZ_MS * CYC_PER_MS;

    // Register offsets
    localparam logic [7:0] OFS_OUT_STATUS = 8'h00;
    localparam logic [7:0] OFS_POS_STATUS = 8'h04;
    localparam logic [7:0] OFS_FAULTS     = 8'h08;
    localparam logic [7:0] OFS_ALARMS     = 8'h0C;
    localparam logic [7:0] OFS_FAULT_CFG  = 8'h10;
    localparam logic [7:0] OFS_CTRL       = 8'h14;
    localparam logic [7:0] OFS_FAULT_LOG  = 8'h18;
    localparam logic [7:0] OFS_ALARM_LOG  = 8'h1C;
    localparam logic [7:0] OFS_REACTION   = 8'h20;

    // Control register and fieldbus status word fields
    localparam int unsigned CTRL_LOCATE_BIT = 8;
    localparam int unsigned CTRL_ACK_BIT    = 9;
    localparam int unsigned FB_READY_BIT    = 0;
    localparam int unsigned FB_FAULT_BIT    = 1;

    // Reset values
    localparam logic [31:0] FAULT_CFG_RST = 32'h0000_0000;
    localparam logic [7:0]  ENC_MASK_RST  = 8'h00;

    // Stop reactions, ordered by severity
    localparam logic [1:0] REACT_NONE  = 2'h0;
    localparam logic [1:0] REACT_RAMP  = 2'h1;
    localparam logic [1:0] REACT_QUICK = 2'h2;
    localparam logic [1:0] REACT_COAST = 2'h3;

    // Acknowledgement classes
    localparam logic [1:0] ACK_IMMEDIATE = 2'h0;
    localparam logic [1:0] ACK_PULSE_INH = 2'h1;
    localparam logic [1:0] ACK_POWER_ON  = 2'h2;

    // Display contents
    localparam logic [1:0] DISP_NONE  = 2'h0;
    localparam logic [1:0] DISP_FAULT = 2'h1;
    localparam logic [1:0] DISP_ALARM = 2'h2;
endpackage : fasi_pkg

// ---- logic/fasi_blinker.sv ----
`timescale 1ns/1ps
module fasi_blinker #(
    parameter int unsigned HALF_CYC = 10
) (
    input  wire logic clock,
    input  wire logic reset_n,
    input  wire logic enable,
    output logic      phase
);
    localparam int unsigned CW = $clog2(HALF_CYC + 1);

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic          ph;
    } fasi_blink_s;

    fasi_blink_s state_r;
    fasi_blink_s state_nxt;

    // Divide the clock down to one toggle per half period
    always_comb begin
        state_nxt = state_r;
        if (!enable) begin
            state_nxt = '0;
        end else if (state_r.cnt == CW'(HALF_CYC - 1)) begin
            state_nxt.cnt = '0;
            state_nxt.ph  = ~state_r.ph;
        end else begin
            state_nxt.cnt = state_r.cnt + CW'(1);
        end
    end

    // State register
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            state_r <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign phase = state_r.ph;
endmodule : fasi_blinker

// ---- logic/fasi_event_log.sv ----
`timescale 1ns/1ps
module fasi_event_log #(
    parameter int unsigned DEPTH = 4,
    parameter int unsigned WIDTH = 8
) (
    input  wire logic                   clock,
    input  wire logic                   reset_n,
    input  wire logic                   push,
    input  wire logic [WIDTH-1:0]       data,
    output logic      [DEPTH*WIDTH-1:0] contents
);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
    } fasi_log_s;

    fasi_log_s state_r;
    fasi_log_s state_nxt;

    // Newest entry at slot 0, oldest drops out
    always_comb begin
        state_nxt = state_r;
        if (push) begin
            for (int i = DEPTH - 1; i > 0; i--) begin
                state_nxt.mem[i] = state_r.mem[i-1];
            end
            state_nxt.mem[0] = data;
        end
    end

    // State register
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            state_r <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign contents = state_r.mem;
endmodule : fasi_event_log

// ---- logic/fasi_status.sv ----
// The strobed register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module fasi_status #(
    parameter int unsigned NF         = 8,
    parameter int unsigned NA         = 8,
    parameter int unsigned RETRY_CYC  = fasi_pkg::RETRY_CYC,
    parameter int unsigned F1HZ_CYC   = fasi_pkg::FLASH_1HZ_CYC,
    parameter int unsigned LOCATE_CYC = fasi_pkg::LOCATE_CYC,
    parameter int unsigned F05_CYC    = fasi_pkg::FLASH_05_CYC,
    parameter int unsigned F2HZ_CYC   = fasi_pkg::FLASH_2HZ_CYC
) (
    input  wire logic          clock,
    input  wire logic          reset_n,
    input  wire logic [7:0]    addr,
    input  wire logic [31:0]   wdata,
    input  wire logic          wr_stb,
    input  wire logic          rd_stb,
    output logic      [31:0]   rdata,
    input  wire logic [NF-1:0] fault_cause,
    input  wire logic [NA-1:0] alarm_cause,
    input  wire logic          drive_ready,
    input  wire logic          in_position_flag,
    input  wire logic          zero_speed_flag,
    input  wire logic          speed_reached_flag,
    input  wire logic          torque_limit_reached,
    input  wire logic          speed_limit_reached,
    input  wire logic          holding_brake_out,
    input  wire logic          overload_level_flag,
    input  wire logic          first_warning_out,
    input  wire logic          second_warning_out,
    input  wire logic          homing_done_flag,
    input  wire logic          control_mode_state,
    input  wire logic [1:0]    gear_ratio_index,
    input  wire logic          servo_on,
    input  wire logic          pulses_inhibited,
    input  wire logic          front_panel_ack,
    input  wire logic          front_panel_key,
    input  wire logic          reset_di,
    input  wire logic          pc_link_active,
    input  wire logic          pc_link_error,
    input  wire logic          card_busy,
    output logic               ramp_stop_reaction,
    output logic               coast_stop_reaction,
    output logic               quick_stop_reaction,
    output logic [15:0]        fieldbus_fault_word,
    output logic [1:0]         display_kind,
    output logic [2:0]         display_index,
    output logic               ready_led_green,
    output logic               ready_led_red,
    output logic               link_led_green,
    output logic               link_led_red
);
    localparam int unsigned RW = $clog2(RETRY_CYC + 1);

    typedef struct packed {
        logic [NF-1:0] cause_q;
        logic [NF-1:0] latched;
        logic [NF-1:0] hidden;
        logic [NA-1:0] alarm_act;
        logic [RW-1:0] retry_cnt;
        logic [31:0]   cfg;
        logic [7:0]    enc_mask;
        logic          locate;
        logic          pc_ack;
        logic          rst_s1;
        logic          rst_s2;
        logic          rst_s3;
        logic [2:0]    react;
        logic [15:0]   fb_word;
        logic [1:0]    disp_kind;
        logic [2:0]    disp_idx;
        logic          rdy_g;
        logic          rdy_r;
        logic          lnk_g;
        logic          lnk_r;
        logic [31:0]   rdata;
    } fasi_state_s;

    fasi_state_s state_r;
    fasi_state_s state_nxt;

    logic        ph_1hz;
    logic        ph_loc;
    logic        ph_05;
    logic        ph_2hz;
    logic [31:0] fault_log;
    logic [31:0] alarm_log;
    logic        ack;
    logic        retry_done;
    logic [NF-1:0] raise;
    logic [NA-1:0] alarm_raise;

    // Lowest set bit of an event vector
    function automatic logic [2:0] first_set(input logic [7:0] v);
        first_set = 3'h0;
        for (int i = 7; i >= 0; i--) begin
            if (v[i]) begin
                first_set = 3'(i);
            end
        end
    endfunction : first_set

    // Blink dividers, enabled only while their pattern is wanted
    fasi_blinker #(.HALF_CYC(F1HZ_CYC)) u_blink_1hz (
        .clock   (clock),
        .reset_n (reset_n),
        .enable  (|state_r.latched | |state_r.alarm_act),
        .phase   (ph_1hz)
    );
    fasi_blinker #(.HALF_CYC(LOCATE_CYC)) u_blink_loc (
        .clock   (clock),
        .reset_n (reset_n),
        .enable  (state_r.locate),
        .phase   (ph_loc)
    );
    fasi_blinker #(.HALF_CYC(F05_CYC)) u_blink_05 (
        .clock   (clock),
        .reset_n (reset_n),
        .enable  (pc_link_active),
        .phase   (ph_05)
    );
    fasi_blinker #(.HALF_CYC(F2HZ_CYC)) u_blink_2hz (
        .clock   (clock),
        .reset_n (reset_n),
        .enable  (card_busy),
        .phase   (ph_2hz)
    );

    // Fault and alarm buffers, entry is valid bit plus index
    fasi_event_log #(.DEPTH(4), .WIDTH(8)) u_fault_log (
        .clock    (clock),
        .reset_n  (reset_n),
        .push     (|raise),
        .data     ({5'h10, first_set(8'(raise))}),
        .contents (fault_log)
    );
    fasi_event_log #(.DEPTH(4), .WIDTH(8)) u_alarm_log (
        .clock    (clock),
        .reset_n  (reset_n),
        .push     (|alarm_raise),
        .data     ({5'h10, first_set(8'(alarm_raise))}),
        .contents (alarm_log)
    );

    // Events of the current cycle
    assign raise       = fault_cause & ~state_r.cause_q;
    assign alarm_raise = alarm_cause & ~state_r.alarm_act;
    assign ack         = front_panel_ack | state_r.pc_ack
                       | (state_r.rst_s2 & ~state_r.rst_s3);
    assign retry_done  = state_r.retry_cnt == RW'(RETRY_CYC - 1);

    // Next-state logic
    always_comb begin
        logic [1:0] cls;
        logic [1:0] rc;
        logic [1:0] sev;
        logic       ok;
        logic [NF-1:0] shown;
        cls   = 2'h0;
        rc    = 2'h0;
        sev   = fasi_pkg::REACT_NONE;
        ok    = 1'b0;
        shown = '0;
        state_nxt = state_r;
        // Reset input synchroniser and edge detect
        state_nxt.rst_s1  = reset_di;
        state_nxt.rst_s2  = state_r.rst_s1;
        state_nxt.rst_s3  = state_r.rst_s2;
        state_nxt.cause_q = fault_cause;
        state_nxt.pc_ack  = 1'b0;
        // Alarms follow their causes, no ack needed
        state_nxt.alarm_act = alarm_cause;
        // Per-fault latch with class-dependent acknowledge
        for (int i = 0; i < NF; i++) begin
            cls = state_r.cfg[4*i+2 +: 2];
            ok  = (cls != fasi_pkg::ACK_POWER_ON)
                && (cls != fasi_pkg::ACK_PULSE_INH
                    || pulses_inhibited);
            if (ack && ok && !fault_cause[i]) begin
                state_nxt.latched[i] = 1'b0;
                state_nxt.hidden[i]  = 1'b0;
            end
            if (ack && ok && fault_cause[i] && state_r.latched[i]) begin
                state_nxt.hidden[i] = 1'b1;
            end
            if (retry_done) begin
                state_nxt.hidden[i] = 1'b0;
            end
            if (fault_cause[i]) begin
                state_nxt.latched[i] = 1'b1;
            end
        end
        // Idle timer for re-display of ignored acknowledges
        if (|state_r.hidden && !front_panel_key && !ack
            && !retry_done) begin
            state_nxt.retry_cnt = state_r.retry_cnt + RW'(1);
        end else begin
            state_nxt.retry_cnt = '0;
        end
        // Worst stop reaction among latched faults only
        for (int i = 0; i < NF; i++) begin
            rc = state_r.cfg[4*i +: 2];
            if (i < 8 && state_r.enc_mask[i % 8]) begin
                rc = fasi_pkg::REACT_COAST;
            end
            if (state_r.latched[i] && rc > sev) begin
                sev = rc;
            end
        end
        state_nxt.react = {sev == fasi_pkg::REACT_QUICK,
                           sev == fasi_pkg::REACT_COAST,
                           sev == fasi_pkg::REACT_RAMP};
        // Fieldbus status word
        state_nxt.fb_word = '0;
        state_nxt.fb_word[fasi_pkg::FB_FAULT_BIT] = |state_r.latched;
        state_nxt.fb_word[fasi_pkg::FB_READY_BIT] = drive_ready;
        // Display: unacknowledged faults beat alarms
        shown = state_r.latched & ~state_r.hidden;
        if (|shown) begin
            state_nxt.disp_kind = fasi_pkg::DISP_FAULT;
            state_nxt.disp_idx  = first_set(8'(shown));
        end else if (|state_r.alarm_act) begin
            state_nxt.disp_kind = fasi_pkg::DISP_ALARM;
            state_nxt.disp_idx  = first_set(8'(state_r.alarm_act));
        end else begin
            state_nxt.disp_kind = fasi_pkg::DISP_NONE;
            state_nxt.disp_idx  = 3'h0;
        end
        // Ready LED: locate, then fault/alarm, then steady
        if (state_r.locate) begin
            state_nxt.rdy_r = 1'b1;
            state_nxt.rdy_g = ph_loc;
        end else if (|state_r.latched || |state_r.alarm_act) begin
            state_nxt.rdy_r = ph_1hz;
            state_nxt.rdy_g = 1'b0;
        end else begin
            state_nxt.rdy_r = !servo_on;
            state_nxt.rdy_g = servo_on;
        end
        // Link LED: error, then card access, then PC link
        if (pc_link_error) begin
            state_nxt.lnk_r = 1'b1;
            state_nxt.lnk_g = 1'b0;
        end else if (card_busy) begin
            state_nxt.lnk_r = 1'b0;
            state_nxt.lnk_g = ph_2hz;
        end else begin
            state_nxt.lnk_r = 1'b0;
            state_nxt.lnk_g = pc_link_active && ph_05;
        end
        // Register writes
        if (wr_stb) begin
            case (addr)
                fasi_pkg::OFS_FAULT_CFG: begin
                    state_nxt.cfg = wdata;
                end
                fasi_pkg::OFS_CTRL: begin
                    state_nxt.enc_mask = wdata[7:0];
                    state_nxt.locate   = wdata[fasi_pkg::CTRL_LOCATE_BIT];
                    state_nxt.pc_ack   = wdata[fasi_pkg::CTRL_ACK_BIT];
                end
                default: begin
                end
            endcase
        end
        // Register reads, data valid the cycle after the strobe
        state_nxt.rdata = 32'h0000_0000;
        if (rd_stb) begin
            case (addr)
                fasi_pkg::OFS_OUT_STATUS: begin
                    state_nxt.rdata[12:0] = {control_mode_state,
                        homing_done_flag, second_warning_out,
                        first_warning_out, overload_level_flag,
                        holding_brake_out, speed_limit_reached,
                        torque_limit_reached, speed_reached_flag,
                        zero_speed_flag, in_position_flag,
                        |state_r.latched, drive_ready};
                end
                fasi_pkg::OFS_POS_STATUS: begin
                    state_nxt.rdata[1:0] = gear_ratio_index;
                end
                fasi_pkg::OFS_FAULTS: begin
                    state_nxt.rdata[15:0] = {8'(state_r.hidden),
                                             8'(state_r.latched)};
                end
                fasi_pkg::OFS_ALARMS: begin
                    state_nxt.rdata[7:0] = 8'(state_r.alarm_act);
                end
                fasi_pkg::OFS_FAULT_CFG: begin
                    state_nxt.rdata = state_r.cfg;
                end
                fasi_pkg::OFS_CTRL: begin
                    state_nxt.rdata[8:0] = {state_r.locate,
                                            state_r.enc_mask};
                end
                fasi_pkg::OFS_FAULT_LOG: begin
                    state_nxt.rdata = fault_log;
                end
                fasi_pkg::OFS_ALARM_LOG: begin
                    state_nxt.rdata = alarm_log;
                end
                fasi_pkg::OFS_REACTION: begin
                    state_nxt.rdata[7:0] = {state_r.disp_idx,
                        state_r.disp_kind, state_r.react};
                end
                default: begin
                end
            endcase
        end
    end

    // State register
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            state_r          <= '0;
            state_r.cfg      <= fasi_pkg::FAULT_CFG_RST;
            state_r.enc_mask <= fasi_pkg::ENC_MASK_RST;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Outputs straight from the state register
    assign rdata               = state_r.rdata;
    assign ramp_stop_reaction  = state_r.react[0];
    assign coast_stop_reaction = state_r.react[1];
    assign quick_stop_reaction = state_r.react[2];
    assign fieldbus_fault_word = state_r.fb_word;
    assign display_kind        = state_r.disp_kind;
    assign display_index       = state_r.disp_idx;
    assign ready_led_green     = state_r.rdy_g;
    assign ready_led_red       = state_r.rdy_r;
    assign link_led_green      = state_r.lnk_g;
    assign link_led_red        = state_r.lnk_r;

    // Per-fault class decode for the checks below
    logic [NF-1:0] cls_pwr;
    logic [NF-1:0] cls_pls;
    for (genvar g = 0; g < NF; g++) begin : g_cls
        assign cls_pwr[g] = state_r.cfg[4*g+2 +: 2] == fasi_pkg::ACK_POWER_ON;
        assign cls_pls[g] = state_r.cfg[4*g+2 +: 2] == fasi_pkg::ACK_PULSE_INH;
    end

    // Checks on the faults and the LED and register outputs
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);

    chk_fault_sets: assert property (
        fault_cause[0] |=> state_r.latched[0])
        else $error("fault not latched");
    chk_fault_sticky: assert property (
        state_r.latched[0] && !ack |=> state_r.latched[0])
        else $error("fault dropped without ack");
    chk_power_class: assert property (
        |(state_r.latched & cls_pwr)
        |=> &(state_r.latched | ~$past(state_r.latched & cls_pwr)))
        else $error("power-on class fault cleared");
    chk_pulse_class: assert property (
        !pulses_inhibited && |(state_r.latched & cls_pls)
        |=> &(state_r.latched | ~$past(state_r.latched & cls_pls)))
        else $error("pulse class cleared with pulses on");
    chk_alarm_clear: assert property (
        !alarm_cause[0] |=> !state_r.alarm_act[0])
        else $error("alarm did not self clear");
    chk_no_alarm_stop: assert property (
        state_r.latched == '0 |=> state_r.react == 3'h0)
        else $error("stop reaction without fault");
    chk_encoder_coast: assert property (
        |(state_r.latched & state_r.enc_mask) |=> coast_stop_reaction)
        else $error("encoder fault not coasting");
    chk_fieldbus_bit: assert property (
        fieldbus_fault_word[1] == $past(|state_r.latched))
        else $error("fieldbus fault bit wrong");
    chk_fault_display: assert property (
        |(state_r.latched & ~state_r.hidden)
        |=> display_kind == fasi_pkg::DISP_FAULT)
        else $error("alarm shown over fault");
    chk_locate_red: assert property (
        state_r.locate |=> ready_led_red)
        else $error("locate pattern lost red");
    chk_flash_no_green: assert property (
        !state_r.locate && (|state_r.latched) |=> !ready_led_green)
        else $error("green shown during fault");
    chk_link_error: assert property (
        pc_link_error |=> link_led_red && !link_led_green)
        else $error("link error not steady red");
    chk_read_status: assert property (
        rd_stb && addr == fasi_pkg::OFS_OUT_STATUS
        |=> rdata[1] == $past(|state_r.latched) && rdata[31:13] == '0)
        else $error("status word fault bit wrong");

    cov_fault_ack: cover property (
        state_r.latched[0] ##1 !state_r.latched[0]);
    cov_retry_redisplay: cover property (
        |state_r.hidden ##1 !(|state_r.hidden) && |state_r.latched);
    cov_alarm_shown: cover property (
        display_kind == fasi_pkg::DISP_ALARM);
endmodule : fasi_status

// ---- dv/fasi_panel_model.sv ----
`timescale 1ns/1ps
module fasi_panel_model (
    input  wire logic clock,
    input  wire logic reset_n,
    input  wire logic key_req,
    input  wire logic pin_req,
    output logic      front_panel_ack,
    output logic      reset_di
);
    logic [2:0] pin_cnt_r;
    // Panel key gives a one-cycle ack, reset pin is held a few cycles
    always_ff @(posedge clock) begin
        front_panel_ack <= reset_n && key_req;
        if (!reset_n) pin_cnt_r <= 3'h0;
        else if (pin_req) pin_cnt_r <= 3'h6;
        else if (pin_cnt_r != 3'h0) pin_cnt_r <= pin_cnt_r - 3'h1;
    end
    assign reset_di = (pin_cnt_r != 3'h0);
endmodule : fasi_panel_model

// ---- dv/tb_fault_alarm_status_indicator.sv ----
`timescale 1ns/1ps
module tb_fault_alarm_status_indicator;
    logic clock = 0, reset_n = 0, wr_stb = 0, rd_stb = 0;
    logic [7:0] addr = 0, fault_cause = 0, alarm_cause = 0;
    logic [31:0] wdata = 0, rdata, seed = 32'h0000_4bac;
    logic [12:0] flg = 0;
    logic [1:0] gear = 0, display_kind;
    logic servo_on = 0, pulses_inhibited = 0, pc_link_error = 0, v;
    logic panel_key = 0, link_act = 0, card = 0;
    logic [2:0] display_index;
    logic key_req = 0, pin_req = 0, front_panel_ack, reset_di;
    logic ramp_stop_reaction, coast_stop_reaction, quick_stop_reaction;
    logic ready_led_green, ready_led_red, link_led_green, link_led_red;
    logic [15:0] fieldbus_fault_word;
    int error_cnt = 0, checks = 0, cyc = 0;

    fasi_status #(.RETRY_CYC(40), .F1HZ_CYC(4), .LOCATE_CYC(4),
        .F05_CYC(8), .F2HZ_CYC(2)) dut (.clock, .reset_n, .addr, .wdata,
        .wr_stb, .rd_stb, .rdata, .fault_cause, .alarm_cause,
        .drive_ready(flg[0]), .in_position_flag(flg[2]),
        .zero_speed_flag(flg[3]), .speed_reached_flag(flg[4]),
        .torque_limit_reached(flg[5]), .speed_limit_reached(flg[6]),
        .holding_brake_out(flg[7]), .overload_level_flag(flg[8]),
        .first_warning_out(flg[9]), .second_warning_out(flg[10]),
        .homing_done_flag(flg[11]), .control_mode_state(flg[12]),
        .gear_ratio_index(gear), .servo_on, .pulses_inhibited,
        .front_panel_ack, .front_panel_key(panel_key), .reset_di,
        .pc_link_active(link_act), .pc_link_error, .card_busy(card),
        .ramp_stop_reaction, .coast_stop_reaction, .quick_stop_reaction,
        .fieldbus_fault_word, .display_kind, .display_index,
        .ready_led_green, .ready_led_red, .link_led_green, .link_led_red);
    fasi_panel_model partner (.clock, .reset_n, .key_req, .pin_req,
        .front_panel_ack, .reset_di);

    // Clock and cycle ceiling
    always #25 clock = ~clock;
    always @(posedge clock) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            conclude();
        end
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        wr_stb <= 1; addr <= a; wdata <= d;
        @(posedge clock);
        wr_stb <= 0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clock);
        rd_stb <= 1; addr <= a;
        @(posedge clock);
        rd_stb <= 0;
        @(posedge clock);
        chk(rdata, exp);
    endtask : rd

    task automatic rst();
        reset_n <= 0;
        repeat (6) @(posedge clock);
        reset_n <= 1;
        @(posedge clock);
    endtask : rst

    // Cause pulse, then idle long enough for outputs to follow
    task automatic raise(input int i);
        fault_cause[i] <= 1;
        repeat (3) @(posedge clock);
        fault_cause[i] <= 0;
        repeat (4) @(posedge clock);
    endtask : raise

    task automatic key_ack();
        key_req <= 1;
        @(posedge clock);
        key_req <= 0;
        repeat (4) @(posedge clock);
    endtask : key_ack

    task automatic conclude();
        if (error_cnt == 0 && checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : conclude

    initial begin
        rst();
        for (int i = 0; i < 8; i++) begin
            seed = lfsr(seed);
            flg <= seed[12:0] & 13'h1ffd;
            gear <= seed[14:13];
            rd(8'h00, {19'h0, seed[12:0] & 13'h1ffd});
            rd(8'h04, {30'h0, seed[14:13]});
        end
        flg <= 0;
        wr(8'h10, 32'h0000_07a1);
        wr(8'h14, 32'h0000_0008);
        raise(0);
        rd(8'h08, 32'h0000_0001);
        chk(fieldbus_fault_word, 32'h0000_0002);
        chk(ramp_stop_reaction, 1);
        key_ack();
        rd(8'h08, 32'h0000_0000);
        raise(3);
        chk(coast_stop_reaction, 1);
        pin_req <= 1;
        @(posedge clock);
        pin_req <= 0;
        repeat (12) @(posedge clock);
        rd(8'h08, 32'h0000_0000);
        raise(2);
        key_ack();
        rd(8'h08, 32'h0000_0004);
        pulses_inhibited <= 1;
        key_ack();
        rd(8'h08, 32'h0000_0000);
        pulses_inhibited <= 0;
        raise(1);
        alarm_cause <= 8'h01;
        wr(8'h14, 32'h0000_0208);
        repeat (4) @(posedge clock);
        rd(8'h08, 32'h0000_0002);
        chk(quick_stop_reaction, 1);
        chk(display_kind, fasi_pkg::DISP_FAULT);
        rst();
        repeat (3) @(posedge clock);
        rd(8'h08, 32'h0000_0000);
        chk(display_kind, fasi_pkg::DISP_ALARM);
        chk({ramp_stop_reaction, coast_stop_reaction,
             quick_stop_reaction}, 0);
        rd(8'h0c, 32'h0000_0001);
        rd(8'h1c, 32'h0000_0080);
        chk(ready_led_green, 0);
        v = ready_led_red;
        repeat (4) @(posedge clock);
        chk(ready_led_red, !v);
        alarm_cause <= 0;
        servo_on <= 1;
        repeat (4) @(posedge clock);
        rd(8'h0c, 32'h0000_0000);
        chk({ready_led_green, ready_led_red}, 2);
        fault_cause[2] <= 1;
        repeat (4) @(posedge clock);
        chk(display_kind, fasi_pkg::DISP_FAULT);
        chk(display_index, 2);
        rd(8'h18, 32'h0000_0082);
        panel_key <= 1;
        key_ack();
        repeat (50) @(posedge clock);
        rd(8'h08, 32'h0000_0404);
        chk(display_kind, fasi_pkg::DISP_NONE);
        panel_key <= 0;
        repeat (50) @(posedge clock);
        chk(display_kind, fasi_pkg::DISP_FAULT);
        fault_cause[2] <= 0;
        key_ack();
        rd(8'h08, 32'h0000_0000);
        servo_on <= 0;
        repeat (3) @(posedge clock);
        chk({ready_led_green, ready_led_red}, 1);
        wr(8'h14, 32'h0000_0100);
        repeat (3) @(posedge clock);
        v = ready_led_green;
        chk(ready_led_red, 1);
        repeat (4) @(posedge clock);
        chk(ready_led_green, !v);
        chk({link_led_green, link_led_red}, 0);
        link_act <= 1;
        repeat (3) @(posedge clock);
        v = link_led_green;
        repeat (8) @(posedge clock);
        chk(link_led_green, !v);
        card <= 1;
        repeat (3) @(posedge clock);
        v = link_led_green;
        repeat (2) @(posedge clock);
        chk(link_led_green, !v);
        pc_link_error <= 1;
        repeat (3) @(posedge clock);
        chk(link_led_red, 1);
        conclude();
    end
endmodule : tb_fault_alarm_status_indicator
